// ### hdl/adc_result_and_correction_regs.sv
// Result, flag, threshold, correction and debug registers of the converter.
//
// Our own choice: the plain strobed port.
`timescale 1ns/100ps
`include "adc_result_map.svh"
module adc_result_and_correction_regs
  import adc_result_pkg::*;
#(
  parameter int SYNC_CYCLES = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        write_protect,
  input  wire logic        debug_halt,
  input  wire logic        raw_valid,
  input  wire logic [15:0] raw_value,
  output logic      [15:0] reg_rdata,
  output logic             irq,
  output logic             converter_enable,
  output logic             converter_halt
);

  // --------------------------------------------------------------------------
  // Elaboration check
  // --------------------------------------------------------------------------
  // The transfer counter is eight bits wide.
  if (SYNC_CYCLES < 1 || SYNC_CYCLES > 255) begin : g_bad_sync
    $error("SYNC_CYCLES must lie between 1 and 255");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic              left_align_select, correction_enable, window_enable, run_while_halted;
  logic              next_left, next_corr, next_winen, next_enable, next_run, next_irq, next_halt;
  logic [2:0]        averaging_config_reg, next_avg;
  logic [3:0]        irq_enable, irq_flag_reg, next_ien, next_flag;
  logic [15:0]       conversion_value, window_lower_bound, window_upper_bound;
  logic [15:0]       next_value, next_lower, next_upper, next_rdata;
  logic [11:0]       gain_factor, offset_trim, next_gain, next_offset;
  logic [10:0]       factory_trim, next_trim;
  sync_state_t       sync_state, next_sync_state;
  logic [7:0]        sync_count, next_sync_count;
  logic              sync_quiet, next_sync_quiet;
  // Decoded strokes of the register port.
  logic wr_ctrl1, wr_ctrl2, wr_avg, wr_ien_clr, wr_ien_set, wr_flag;
  logic wr_lower, wr_upper, wr_gain, wr_offset, wr_trim, wr_debug;
  logic rd_value, soft_reset, enable_write, sync_start, sync_fall, accept;

  // Write-protected registers ignore writes while the protection input is high.
  assign wr_ctrl1   = reg_wr && reg_addr == `OFS_CONTROL_ONE && !write_protect;
  assign wr_ctrl2   = reg_wr && reg_addr == `OFS_CONTROL_TWO;
  assign wr_avg     = reg_wr && reg_addr == `OFS_AVERAGING && !write_protect;
  assign wr_ien_clr = reg_wr && reg_addr == `OFS_IRQ_EN_CLEAR && !write_protect;
  assign wr_ien_set = reg_wr && reg_addr == `OFS_IRQ_EN_SET && !write_protect;
  assign wr_flag    = reg_wr && reg_addr == `OFS_IRQ_FLAG;
  assign wr_lower   = reg_wr && reg_addr == `OFS_WIN_LOWER && !write_protect;
  assign wr_upper   = reg_wr && reg_addr == `OFS_WIN_UPPER && !write_protect;
  assign wr_gain    = reg_wr && reg_addr == `OFS_GAIN && !write_protect;
  assign wr_offset  = reg_wr && reg_addr == `OFS_OFFSET && !write_protect;
  assign wr_trim    = reg_wr && reg_addr == `OFS_TRIM && !write_protect;
  assign wr_debug   = reg_wr && reg_addr == `OFS_DEBUG && !write_protect;
  assign rd_value   = reg_rd && reg_addr == `OFS_CONV_VALUE;
  assign soft_reset   = wr_ctrl1 && reg_wdata[`BIT_SOFT_RESET];
  assign enable_write = wr_ctrl1 && !reg_wdata[`BIT_SOFT_RESET];

  // A result is taken only while enabled and not held by the debugger.
  assign accept = raw_valid && converter_enable && !converter_halt;

  // --------------------------------------------------------------------------
  // Correction and formatting
  // --------------------------------------------------------------------------
  logic signed [13:0] corr_diff;
  logic signed [26:0] corr_prod, corr_scaled;
  logic        [11:0] corr_value;
  logic        [15:0] formatted;
  logic               window_hit;

  always_comb begin
    corr_diff   = $signed({2'b00, raw_value[11:0]}) - $signed({{2{offset_trim[11]}}, offset_trim});
    corr_prod   = corr_diff * $signed({1'b0, gain_factor});
    corr_scaled = corr_prod >>> `GAIN_FRAC_BITS;
    // Saturate rather than wrap, so a slight overshoot never reads as a tiny value.
    if (corr_scaled < 0) begin
      corr_value = `RST_ZERO12;
    end else if (corr_scaled > $signed({15'd0, `VALUE_MAX12})) begin
      corr_value = `VALUE_MAX12;
    end else begin
      corr_value = corr_scaled[11:0];
    end
    if (!correction_enable) begin
      corr_value = raw_value[11:0];
    end
    if (averaging_config_reg != `RST_ZERO3) begin
      formatted = raw_value;
    end else if (left_align_select) begin
      formatted = {corr_value, `RST_ZERO4};
    end else begin
      formatted = {`RST_ZERO4, corr_value};
    end
    window_hit = window_enable && formatted >= window_lower_bound && formatted <= window_upper_bound;
  end
  // --------------------------------------------------------------------------
  // Domain transfer status
  // --------------------------------------------------------------------------
  // Writes of write-synchronized registers start a transfer.
  assign sync_start = wr_lower || wr_upper || wr_ctrl1;
  assign sync_fall  = sync_state == SYNC_BUSY && sync_count == 8'd1 && !sync_start;

  // The transfer is modelled as a fixed count; a new start reloads it.
  always_comb begin
    next_sync_state = sync_state;
    next_sync_count = sync_count;
    next_sync_quiet = sync_quiet;
    if (sync_start) begin
      next_sync_state = SYNC_BUSY;
      next_sync_count = SYNC_CYCLES[7:0];
      next_sync_quiet = wr_ctrl1;
    end else begin
      case (sync_state)
        SYNC_IDLE: next_sync_count = 8'd0;
        SYNC_BUSY: begin
          next_sync_count = sync_count - 8'd1;
          if (sync_fall) begin
            next_sync_state = SYNC_IDLE;
          end
        end
        default: begin
          next_sync_state = SYNC_IDLE;
          next_sync_count = 8'd0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sync_state <= SYNC_IDLE;
      sync_count <= 8'd0;
      sync_quiet <= 1'b0;
    end else begin
      sync_state <= next_sync_state;
      sync_count <= next_sync_count;
      sync_quiet <= next_sync_quiet;
    end
  end

  // --------------------------------------------------------------------------
  // Registers and flags
  // --------------------------------------------------------------------------
  always_comb begin
    next_left   = left_align_select;
    next_corr   = correction_enable;
    next_winen  = window_enable;
    next_avg    = averaging_config_reg;
    next_enable = converter_enable;
    next_ien    = irq_enable;
    next_flag   = irq_flag_reg;
    next_value  = conversion_value;
    next_lower  = window_lower_bound;
    next_upper  = window_upper_bound;
    next_gain   = gain_factor;
    next_offset = offset_trim;
    next_trim   = factory_trim;
    next_run    = run_while_halted;
    if (wr_ctrl2) begin
      next_left  = reg_wdata[`BIT_LEFT_ALIGN];
      next_corr  = reg_wdata[`BIT_CORR_ENABLE];
      next_winen = reg_wdata[`BIT_WIN_ENABLE];
    end
    if (wr_avg)     next_avg    = reg_wdata[2:0];
    if (enable_write) next_enable = reg_wdata[`BIT_ENABLE];
    if (wr_ien_clr) next_ien    = irq_enable & ~reg_wdata[3:0];
    if (wr_ien_set) next_ien    = irq_enable | reg_wdata[3:0];
    if (wr_lower)   next_lower  = reg_wdata;
    if (wr_upper)   next_upper  = reg_wdata;
    if (wr_gain)    next_gain   = reg_wdata[11:0];
    if (wr_offset)  next_offset = reg_wdata[11:0];
    if (wr_trim)    next_trim   = reg_wdata[10:0];
    if (wr_debug && !converter_enable) next_run = reg_wdata[`BIT_RUN_HALTED];
    if (wr_flag) next_flag = irq_flag_reg & ~reg_wdata[3:0];
    // Reading the result clears done and window flags
    if (rd_value) begin
      next_flag[`BIT_DONE]      = 1'b0;
      next_flag[`BIT_WIN_MATCH] = 1'b0;
    end
    // Sets follow the read and flag-write clears so an event beside them is never lost.
    if (accept) begin
      next_value = formatted;
      next_flag[`BIT_DONE] = 1'b1;
      if (irq_flag_reg[`BIT_DONE] && !rd_value) next_flag[`BIT_LOST] = 1'b1;
      if (window_hit) next_flag[`BIT_WIN_MATCH] = 1'b1;
    end
    // Busy fall sets ready unless enable or reset caused it
    if (sync_fall && !sync_quiet) next_flag[`BIT_SYNC_READY] = 1'b1;
    if (soft_reset) begin
      next_left   = 1'b0;
      next_corr   = 1'b0;
      next_winen  = 1'b0;
      next_avg    = `RST_ZERO3;
      next_enable = 1'b0;
      next_ien    = `RST_ZERO4;
      next_flag   = `RST_ZERO4;
      next_value  = `RST_ZERO16;
      next_lower  = `RST_ZERO16;
      next_upper  = `RST_ZERO16;
      next_gain   = `RST_GAIN;
      next_offset = `RST_ZERO12;
      next_trim   = `RST_ZERO11;
      next_run    = 1'b0;
    end
    // Interrupt when flag and enable meet
    next_irq  = |(next_flag & next_ien);
    // Halt in debug unless told to run
    next_halt = debug_halt && !next_run;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      left_align_select    <= 1'b0;
      correction_enable    <= 1'b0;
      window_enable        <= 1'b0;
      averaging_config_reg <= `RST_ZERO3;
      converter_enable     <= 1'b0;
      irq_enable           <= `RST_ZERO4;
      irq_flag_reg         <= `RST_ZERO4;
      conversion_value     <= `RST_ZERO16;
      window_lower_bound   <= `RST_ZERO16;
      window_upper_bound   <= `RST_ZERO16;
      gain_factor          <= `RST_GAIN;
      offset_trim          <= `RST_ZERO12;
      factory_trim         <= `RST_ZERO11;
      run_while_halted     <= 1'b0;
      irq                  <= 1'b0;
      converter_halt       <= 1'b0;
    end else begin
      left_align_select    <= next_left;
      correction_enable    <= next_corr;
      window_enable        <= next_winen;
      averaging_config_reg <= next_avg;
      converter_enable     <= next_enable;
      irq_enable           <= next_ien;
      irq_flag_reg         <= next_flag;
      conversion_value     <= next_value;
      window_lower_bound   <= next_lower;
      window_upper_bound   <= next_upper;
      gain_factor          <= next_gain;
      offset_trim          <= next_offset;
      factory_trim         <= next_trim;
      run_while_halted     <= next_run;
      irq                  <= next_irq;
      converter_halt       <= next_halt;
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Read data stand one cycle only; unmapped offsets read zero.
  always_comb begin
    next_rdata = `RST_ZERO16;
    if (reg_rd) begin
      case (reg_addr)
        `OFS_CONTROL_ONE:  next_rdata = {14'd0, converter_enable, 1'b0};
        `OFS_CONTROL_TWO:  next_rdata = {13'd0, window_enable, correction_enable, left_align_select};
        `OFS_AVERAGING:    next_rdata = {13'd0, averaging_config_reg};
        `OFS_IRQ_EN_CLEAR: next_rdata = {12'd0, irq_enable};
        `OFS_IRQ_EN_SET:   next_rdata = {12'd0, irq_enable};
        `OFS_IRQ_FLAG:     next_rdata = {12'd0, irq_flag_reg};
        `OFS_SYNC_STATUS:  next_rdata = {8'd0, sync_state == SYNC_BUSY, 7'd0};
        `OFS_CONV_VALUE:   next_rdata = conversion_value;
        `OFS_WIN_LOWER:    next_rdata = window_lower_bound;
        `OFS_WIN_UPPER:    next_rdata = window_upper_bound;
        `OFS_GAIN:         next_rdata = {4'd0, gain_factor};
        `OFS_OFFSET:       next_rdata = {4'd0, offset_trim};
        `OFS_TRIM:         next_rdata = {5'd0, factory_trim};
        `OFS_DEBUG:        next_rdata = {15'd0, run_while_halted};
        default:           next_rdata = `RST_ZERO16;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `RST_ZERO16;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_lost_on_unread: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && irq_flag_reg[`BIT_DONE] && !rd_value && !soft_reset |=> irq_flag_reg[`BIT_LOST])
    else $error("overrun not flagged");
  a_done_then_irq: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && irq_enable[`BIT_DONE] && !soft_reset && !wr_ien_clr |=> irq_flag_reg[`BIT_DONE] && irq)
    else $error("done flag or interrupt missing");
  a_read_clears_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_value && !accept |=> !irq_flag_reg[`BIT_DONE])
    else $error("result read left done flag set");
  a_lost_fall_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(irq_flag_reg[`BIT_LOST]) |-> $past(soft_reset || (wr_flag && reg_wdata[`BIT_LOST])))
    else $error("overrun flag cleared without a one");
  a_busy_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sync_start |=> sync_state == SYNC_BUSY && sync_count == SYNC_CYCLES[7:0])
    else $error("transfer did not start busy");
  a_left_format: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && !soft_reset && left_align_select && !correction_enable && averaging_config_reg == `RST_ZERO3
    |=> conversion_value == {$past(raw_value[11:0]), 4'h0})
    else $error("left aligned value misplaced");
  a_right_format: assert property (@(posedge clk_sys) disable iff (sys_rst)
    accept && !soft_reset && !left_align_select && !correction_enable && averaging_config_reg == `RST_ZERO3
    |=> conversion_value == {4'h0, $past(raw_value[11:0])})
    else $error("right aligned value misplaced");
  a_run_locked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $changed(run_while_halted) |-> $past(!converter_enable || soft_reset))
    else $error("debug run bit changed while enabled");
  a_ready_on_fall: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sync_fall && !sync_quiet && !soft_reset |=> irq_flag_reg[`BIT_SYNC_READY])
    else $error("sync ready not set on busy fall");
  a_rdata_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside the answer cycle");
endmodule : adc_result_and_correction_regs

// ### hdl/adc_result_map.svh
// Register offsets, field positions and reset values of the converter result block.
`ifndef ADC_RESULT_MAP_SVH
`define ADC_RESULT_MAP_SVH
// --------------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------------
`define OFS_CONTROL_ONE   8'h00
`define OFS_CONTROL_TWO   8'h01
`define OFS_AVERAGING     8'h02
`define OFS_IRQ_EN_CLEAR  8'h16
`define OFS_IRQ_EN_SET    8'h17
`define OFS_IRQ_FLAG      8'h18
`define OFS_SYNC_STATUS   8'h19
`define OFS_CONV_VALUE    8'h1A
`define OFS_WIN_LOWER     8'h1C
`define OFS_WIN_UPPER     8'h20
`define OFS_GAIN          8'h24
`define OFS_OFFSET        8'h26
`define OFS_TRIM          8'h28
`define OFS_DEBUG         8'h2A
// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define BIT_SOFT_RESET    0
`define BIT_ENABLE        1
`define BIT_LEFT_ALIGN    0
`define BIT_CORR_ENABLE   1
`define BIT_WIN_ENABLE    2
`define BIT_DONE          0
`define BIT_LOST          1
`define BIT_WIN_MATCH     2
`define BIT_SYNC_READY    3
`define BIT_SYNC_BUSY     7
`define BIT_RUN_HALTED    0
`define GAIN_FRAC_BITS    11
// --------------------------------------------------------------------------
// Reset values and limits
// --------------------------------------------------------------------------
`define RST_GAIN          12'h800
`define RST_ZERO16        16'h0000
`define RST_ZERO12        12'h000
`define RST_ZERO11        11'h000
`define RST_ZERO4         4'h0
`define RST_ZERO3         3'h0
`define VALUE_MAX12       12'hFFF
`endif

// ### hdl/adc_result_pkg.sv
// Types shared by the converter result block.
package adc_result_pkg;
  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b01,
    SYNC_BUSY = 2'b10
  } sync_state_t;
endpackage : adc_result_pkg

// ### verif/tb_adc_result_and_correction_regs.sv
// Self-checking bench for the converter result, flag, threshold and debug registers.
`timescale 1ns/100ps

module tb_adc_result_and_correction_regs;
  // --------------------------------------------------------------------------
  // Signals and stimulus table
  // --------------------------------------------------------------------------
  typedef struct {
    logic [15:0] ctl2;
    logic [15:0] avg;
    logic [15:0] gain;
    logic [15:0] ofs;
    logic [15:0] raw;
    logic [15:0] exp;
  } row_t;
  logic        clk_sys;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        write_protect;
  logic        debug_halt;
  logic        raw_valid;
  logic [15:0] raw_value;
  logic [15:0] reg_rdata;
  logic        irq;
  logic        converter_enable;
  logic        converter_halt;
  logic [15:0] d;
  int          error_cnt;
  int          total_checks;
  // Upper bits of raw are ignored in plain mode, so row zero hides junk there.
  row_t rows[8] = '{
    '{16'h0000, 16'h0000, 16'h0800, 16'h0000, 16'hFABC, 16'h0ABC},
    '{16'h0001, 16'h0000, 16'h0800, 16'h0000, 16'h0ABC, 16'hABC0},
    '{16'h0002, 16'h0001, 16'h0800, 16'h0000, 16'hFABC, 16'hFABC},
    '{16'h0002, 16'h0000, 16'h0400, 16'h0010, 16'h0210, 16'h0100},
    '{16'h0002, 16'h0000, 16'h0C00, 16'h0FF0, 16'h0100, 16'h0198},
    '{16'h0002, 16'h0000, 16'h0800, 16'h0010, 16'h0005, 16'h0000},
    '{16'h0002, 16'h0000, 16'h0FFF, 16'h0000, 16'h0FFF, 16'h0FFF},
    '{16'h0003, 16'h0000, 16'h0400, 16'h0010, 16'h0210, 16'h1000}
  };

  adc_result_and_correction_regs #(.SYNC_CYCLES(4)) u_adc_result_and_correction_regs (
    .clk_sys          (clk_sys),
    .sys_rst          (sys_rst),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .write_protect    (write_protect),
    .debug_halt       (debug_halt),
    .raw_valid        (raw_valid),
    .raw_value        (raw_value),
    .reg_rdata        (reg_rdata),
    .irq              (irq),
    .converter_enable (converter_enable),
    .converter_halt   (converter_halt)
  );

  // --------------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------------
  // Every strobe is raised right after an edge and dropped after the sampling edge.
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the read edge, so it is taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask : rd

  task automatic conv(input logic [15:0] v);
    @(posedge clk_sys);
    raw_valid <= 1'b1;
    raw_value <= v;
    @(posedge clk_sys);
    raw_valid <= 1'b0;
  endtask : conv

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // The whole run needs well under a thousand cycles; a hang is cut at five thousand.
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    sys_rst       = 1'b1;
    reg_addr      = 8'h00;
    reg_wdata     = 16'h0000;
    reg_wr        = 1'b0;
    reg_rd        = 1'b0;
    write_protect = 1'b0;
    debug_halt    = 1'b0;
    raw_valid     = 1'b0;
    raw_value     = 16'h0000;
    error_cnt     = 0;
    total_checks  = 0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    // Reset values, including an unmapped offset that must read zero.
    rd(8'h19, d);
    chk("status", 16'h0000, d);
    rd(8'h1A, d);
    chk("result", 16'h0000, d);
    rd(8'h1C, d);
    chk("lower", 16'h0000, d);
    rd(8'h20, d);
    chk("upper", 16'h0000, d);
    rd(8'h2A, d);
    chk("debug", 16'h0000, d);
    rd(8'h24, d);
    chk("gain", 16'h0800, d);
    rd(8'h30, d);
    chk("unmapped", 16'h0000, d);
    wr(8'h00, 16'h0002);
    #1 chk("enable", 16'h0001, {15'h0, converter_enable});
    // Formatting and correction of every row; the result register ignores writes.
    foreach (rows[i]) begin
      wr(8'h01, rows[i].ctl2);
      wr(8'h02, rows[i].avg);
      wr(8'h24, rows[i].gain);
      wr(8'h26, rows[i].ofs);
      conv(rows[i].raw);
      wr(8'h1A, 16'h5555);
      rd(8'h1A, d);
      chk("formatted", rows[i].exp, d);
    end
    // Done, lost, zero writes and the interrupt line.
    wr(8'h01, 16'h0000);
    wr(8'h18, 16'h000F);
    wr(8'h17, 16'h0003);
    conv(16'h0011);
    rd(8'h18, d);
    chk("flags one", 16'h0001, d & 16'h0003);
    conv(16'h0022);
    rd(8'h18, d);
    chk("flags two", 16'h0003, d & 16'h0003);
    wr(8'h18, 16'h0000);
    rd(8'h18, d);
    chk("zero write", 16'h0003, d & 16'h0003);
    #1 chk("irq on", 16'h0001, {15'h0, irq});
    wr(8'h18, 16'h0002);
    rd(8'h18, d);
    chk("lost clear", 16'h0001, d & 16'h0003);
    rd(8'h1A, d);
    chk("last value", 16'h0022, d);
    rd(8'h18, d);
    chk("read clears", 16'h0000, d & 16'h0003);
    @(posedge clk_sys);
    #1 chk("irq off", 16'h0000, {15'h0, irq});
    wr(8'h16, 16'h000F);
    // Threshold writes start a transfer and raise sync ready when it ends.
    repeat (8) @(posedge clk_sys);
    wr(8'h18, 16'h0008);
    wr(8'h1C, 16'h0100);
    rd(8'h19, d);
    chk("busy", 16'h0080, d);
    repeat (8) @(posedge clk_sys);
    rd(8'h19, d);
    chk("idle", 16'h0000, d);
    rd(8'h18, d);
    chk("sync ready", 16'h0008, d & 16'h0008);
    rd(8'h1C, d);
    chk("lower set", 16'h0100, d);
    @(posedge clk_sys);
    write_protect <= 1'b1;
    wr(8'h20, 16'h0200);
    write_protect <= 1'b0;
    rd(8'h20, d);
    chk("protected", 16'h0000, d);
    wr(8'h20, 16'h0200);
    rd(8'h20, d);
    chk("upper set", 16'h0200, d);
    // Window flag at the upper boundary, then outside it.
    wr(8'h01, 16'h0004);
    wr(8'h18, 16'h000F);
    conv(16'h0200);
    rd(8'h18, d);
    chk("window in", 16'h0004, d & 16'h0004);
    rd(8'h1A, d);
    rd(8'h18, d);
    chk("window read", 16'h0000, d & 16'h0005);
    conv(16'h0300);
    rd(8'h18, d);
    chk("window out", 16'h0000, d & 16'h0004);
    rd(8'h1A, d);
    // Debug run bit is locked while enabled, and halting drops results.
    @(posedge clk_sys);
    debug_halt <= 1'b1;
    wr(8'h2A, 16'h0001);
    rd(8'h2A, d);
    chk("debug locked", 16'h0000, d);
    chk("halted", 16'h0001, {15'h0, converter_halt});
    conv(16'h0123);
    rd(8'h18, d);
    chk("halt drops", 16'h0000, d & 16'h0001);
    wr(8'h00, 16'h0000);
    wr(8'h2A, 16'h0001);
    rd(8'h2A, d);
    chk("debug set", 16'h0001, d);
    wr(8'h00, 16'h0002);
    @(posedge clk_sys);
    #1 chk("run halted", 16'h0000, {15'h0, converter_halt});
    // Soft reset returns every register but the sync status to its reset value.
    wr(8'h00, 16'h0001);
    #1 chk("soft enable", 16'h0000, {15'h0, converter_enable});
    rd(8'h1C, d);
    chk("soft lower", 16'h0000, d);
    rd(8'h24, d);
    chk("soft gain", 16'h0800, d);
    // Trim fields are kept exactly as software copies them in.
    wr(8'h28, 16'h0345);
    rd(8'h28, d);
    chk("trim copy", 16'h0345, d);
    report_and_stop();
  end
endmodule : tb_adc_result_and_correction_regs
